// ---- hw/ubpt_defs.svh ----
// Offsets, tie-off masks and constants for the unbonded port tie-off block
`ifndef UBPT_DEFS_SVH
`define UBPT_DEFS_SVH
`define UBPT_ADDR_W 5
// Register index = port slot * 4 + kind (0 level, 1 latch, 2 direction, 3 function)
`define UBPT_KIND_LEVEL 2'h0
`define UBPT_KIND_LATCH 2'h1
`define UBPT_KIND_DIR 2'h2
`define UBPT_KIND_FUNC 2'h3
`define UBPT_SLOT_P1 3'h0
`define UBPT_SLOT_P2 3'h1
`define UBPT_SLOT_P5 3'h2
`define UBPT_SLOT_P6 3'h3
`define UBPT_SLOT_P0 3'h4
`define UBPT_SLOT_ADC 3'h5
`define UBPT_NUM_PORTS 4
// Fixed bit masks per port slot
`define UBPT_FIX_P1 8'hF0
`define UBPT_FIX_P2 8'h28
`define UBPT_FIX_P5 8'h82
`define UBPT_FIX_P6 8'h0C
// Value of fixed function-select bits
`define UBPT_FUNC_P1 8'h00
`define UBPT_FUNC_P2 8'h00
`define UBPT_FUNC_P5 8'h80
`define UBPT_FUNC_P6 8'h00
`define UBPT_P0_TIED 8'h03
`define UBPT_CLOCK_OUTPUT_BIT 7
`define UBPT_FULL_SCALE 10'h3FF
`define UBPT_RST_LATCH 8'hFF
`define UBPT_RST_DIR 8'hFF
`define UBPT_RST_FUNC 8'h00
// Reset values of bonded bits: latch high, input direction, plain I/O
`define UBPT_ADC_START 1'h0
`define UBPT_ADC_CONV_CYC 4'hA
`endif

// ---- hw/ubpt_pkg.sv ----
// Types for the unbonded port tie-off block
package ubpt_pkg;
  typedef struct packed {
    logic [7:0] latch;
    logic [7:0] dir;
    logic [7:0] func;
  } ubpt_port_s;
  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ubpt_bus_s;
  typedef enum logic [1:0] {ADC_IDLE, ADC_BUSY, ADC_DONE} ubpt_adc_e;
  typedef struct packed {
    ubpt_port_s [3:0] port;
    logic [7:0] p0Latch;
    logic [7:0] rdata;
    ubpt_adc_e adcState;
    logic [3:0] adcCnt;
    logic [2:0] adcChan;
    logic [9:0] adcResult;
  } ubpt_state_s;
endpackage

// ---- hw/ubpt_port_bits.sv ----
// One port: applies tie-off masks to stored bits and to the pin level
`timescale 1ns/1ps
`include "ubpt_defs.svh"
module ubpt_port_bits
  import ubpt_pkg::*;
#(
  parameter logic [7:0] FIX_MASK = 8'h00,
  parameter logic [7:0] FIX_FUNC = 8'h00
) (
  // Stored and pin state
  input wire ubpt_port_s stored,
  input wire logic [7:0] pinLevel,
  // Masked views
  output logic [7:0] levelView,
  output logic [7:0] latchView,
  output logic [7:0] dirView,
  output logic [7:0] funcView
);
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : gBit
      if (FIX_MASK[i]) begin : gFixed
        assign levelView[i] = 1'b1; // see [R1] see [R2] see [R3] see [R4]
        assign latchView[i] = 1'b1;
        assign dirView[i] = 1'b1;
        assign funcView[i] = FIX_FUNC[i];
      end else begin : gBonded
        assign levelView[i] = pinLevel[i]; // see [R9]
        assign latchView[i] = stored.latch[i];
        assign dirView[i] = stored.dir[i];
        assign funcView[i] = stored.func[i];
      end
    end
  endgenerate
endmodule

// ---- hw/ubpt_top.sv ----
// Port registers with tie-offs for unbonded pins, port 0 and converter stub
//
// What this block does
// [R1] Port 1 bits 4..7 read 1 in level, latch and direction and 0 in function select.
// [R2] Port 2 bits 3 and 5 read 1 in level, latch and direction and 0 in function select.
// [R3] Port 5 bits 1 and 7 read 1 in level, latch and direction; function reads 0 at 1, 1 at 7.
// [R4] Port 6 bits 2 and 3 read 1 in level, latch and direction and 0 in function select.
// [R5] Writes to any fixed bit of an unbonded pin are ignored.
// [R6] A conversion on analog channel zero or one returns full scale 3FF.
// [R7] Port 0 bits 0 and 1 always read 0 in the level register; latch reads return them as written.
// [R8] The clock output pin on port 2 bit 7 never behaves as open drain.
// [R9] Bonded bits keep their ordinary read, write and direction behaviour.
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "ubpt_defs.svh"
module ubpt_top
  import ubpt_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Register port
  input wire logic [4:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Pin levels
  input wire logic [7:0] port0Pin,
  input wire logic [7:0] port1Pin,
  input wire logic [7:0] port2Pin,
  input wire logic [7:0] port5Pin,
  input wire logic [7:0] port6Pin,
  // Pin drive, enable low while driving
  output logic [7:0] port1Out,
  output logic [7:0] port1OutEn_n,
  output logic [7:0] port2Out,
  output logic [7:0] port2OutEn_n,
  output logic [7:0] port5Out,
  output logic [7:0] port5OutEn_n,
  output logic [7:0] port6Out,
  output logic [7:0] port6OutEn_n,
  // Clock output source on port 2 bit 7
  input wire logic clockOutSrc,
  // Converter samples for bonded channels
  input wire logic [9:0] adcSample,
  output logic adcBusy
);
  localparam logic [7:0] FIX_M [4] = '{`UBPT_FIX_P1, `UBPT_FIX_P2, `UBPT_FIX_P5, `UBPT_FIX_P6};
  localparam logic [7:0] FIX_F [4] = '{`UBPT_FUNC_P1, `UBPT_FUNC_P2, `UBPT_FUNC_P5, `UBPT_FUNC_P6};

  ubpt_state_s st;
  ubpt_state_s next_st;
  logic [7:0] pins [4];
  logic [7:0] lvl [4];
  logic [7:0] lat [4];
  logic [7:0] dir [4];
  logic [7:0] fsel [4];
  logic [7:0] drv [4];
  logic [7:0] en [4];

  assign pins[0] = port1Pin;
  assign pins[1] = port2Pin;
  assign pins[2] = port5Pin;
  assign pins[3] = port6Pin;

  genvar p;
  generate
    for (p = 0; p < `UBPT_NUM_PORTS; p++) begin : gPort
      ubpt_port_bits #(
        .FIX_MASK(FIX_M[p]),
        .FIX_FUNC(FIX_F[p])
      ) uBits (
        .stored(st.port[p]),
        .pinLevel(pins[p]),
        .levelView(lvl[p]),
        .latchView(lat[p]),
        .dirView(dir[p]),
        .funcView(fsel[p])
      );
      // Direction 1 = open-drain/quasi input: drive only a low latch
      always_comb begin
        for (int b = 0; b < 8; b++) begin
          if (FIX_M[p][b]) begin
            drv[p][b] = 1'b1;
            en[p][b] = 1'b1;
          end else if (st.port[p].dir[b]) begin
            drv[p][b] = 1'b0;
            en[p][b] = lat[p][b];
          end else begin
            drv[p][b] = lat[p][b]; // see [R9]
            en[p][b] = 1'b0;
          end
        end
        // Clock output always push-pull, direction ignored
        if (p == 1 && fsel[p][7]) begin
          drv[p][7] = clockOutSrc;
          en[p][7] = 1'b0; // see [R8]
        end
      end
    end
  endgenerate

  assign port1Out = drv[0];
  assign port1OutEn_n = en[0];
  assign port2Out = drv[1];
  assign port2OutEn_n = en[1];
  assign port5Out = drv[2];
  assign port5OutEn_n = en[2];
  assign port6Out = drv[3];
  assign port6OutEn_n = en[3];
  assign rdata = st.rdata;
  assign adcBusy = (st.adcState == ADC_BUSY);

  always_comb begin
    logic [2:0] slot;
    logic [1:0] kind;
    slot = addr[4:2];
    kind = addr[1:0];
    next_st = st;
    next_st.rdata = 8'h00;
    if (wr) begin
      if (slot < 3'h4) begin
        // Fixed bits keep stored value, bonded bits take the write
        unique case (kind)
          `UBPT_KIND_LATCH: next_st.port[slot[1:0]].latch = // see [R5]
            (st.port[slot[1:0]].latch & FIX_M[slot[1:0]]) | (wdata & ~FIX_M[slot[1:0]]);
          `UBPT_KIND_DIR: next_st.port[slot[1:0]].dir =
            (st.port[slot[1:0]].dir & FIX_M[slot[1:0]]) | (wdata & ~FIX_M[slot[1:0]]); // see [R5]
          `UBPT_KIND_FUNC: next_st.port[slot[1:0]].func =
            (st.port[slot[1:0]].func & FIX_M[slot[1:0]]) | (wdata & ~FIX_M[slot[1:0]]); // see [R5]
          default: next_st.port[slot[1:0]] = st.port[slot[1:0]];
        endcase
      end else if (slot == `UBPT_SLOT_P0 && kind == `UBPT_KIND_LATCH) begin
        next_st.p0Latch = wdata;
      end else if (slot == `UBPT_SLOT_ADC && kind == 2'h0 && st.adcState != ADC_BUSY) begin
        // Start conversion; channel in low bits
        next_st.adcChan = wdata[2:0];
        next_st.adcCnt = `UBPT_ADC_CONV_CYC;
        next_st.adcState = ADC_BUSY;
      end
    end
    unique case (st.adcState)
      ADC_IDLE: ;
      ADC_BUSY: begin
        if (st.adcCnt == 4'h0) begin
          if (st.adcChan < 3'h2)
            next_st.adcResult = `UBPT_FULL_SCALE; // see [R6]
          else
            next_st.adcResult = adcSample;
          next_st.adcState = ADC_DONE;
        end else begin
          next_st.adcCnt = st.adcCnt - 4'h1;
        end
      end
      ADC_DONE: ;
    endcase
    if (rd) begin
      if (slot < 3'h4) begin
        unique case (kind)
          `UBPT_KIND_LEVEL: next_st.rdata = lvl[slot[1:0]];
          `UBPT_KIND_LATCH: next_st.rdata = lat[slot[1:0]];
          `UBPT_KIND_DIR: next_st.rdata = dir[slot[1:0]];
          `UBPT_KIND_FUNC: next_st.rdata = fsel[slot[1:0]];
        endcase
      end else if (slot == `UBPT_SLOT_P0) begin
        if (kind == `UBPT_KIND_LEVEL)
          next_st.rdata = port0Pin & ~`UBPT_P0_TIED; // see [R7]
        else if (kind == `UBPT_KIND_LATCH)
          next_st.rdata = st.p0Latch;
      end else if (slot == `UBPT_SLOT_ADC) begin
        unique case (kind)
          2'h0: next_st.rdata = {6'h00, st.adcState == ADC_DONE, adcBusy};
          2'h1: next_st.rdata = st.adcResult[7:0];
          2'h2: next_st.rdata = {5'h00, st.adcResult[9:8], 1'b0} >> 1;
          2'h3: next_st.rdata = {5'h00, st.adcChan};
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      for (int i = 0; i < 4; i++) begin
        st.port[i].latch <= `UBPT_RST_LATCH;
        st.port[i].dir <= `UBPT_RST_DIR;
        st.port[i].func <= `UBPT_RST_FUNC;
      end
      st.p0Latch <= 8'h00;
      st.rdata <= 8'h00;
      st.adcState <= ADC_IDLE;
      st.adcCnt <= 4'h0;
      st.adcChan <= 3'h0;
      st.adcResult <= 10'h000;
    end else begin
      st <= next_st;
    end
  end
endmodule

// ---- verif/ubpt_monitor.sv ----
// Port-side checker for the unbonded port tie-off block
`timescale 1ns/1ps
module ubpt_monitor (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Register port
  input wire logic [4:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  // Pin side
  input wire logic [7:0] port1OutEn_n,
  input wire logic [7:0] port6OutEn_n,
  input wire logic adcBusy
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  p1_tieoff_a: assert property (rd && addr[4:2] == 3'h0
    |=> rdata[7:4] == {4{$past(addr[1:0]) != 2'h3}}) else $error("port 1 tie-off wrong");
  p2_tieoff_a: assert property (rd && addr[4:2] == 3'h1
    |=> {rdata[5], rdata[3]} == {2{$past(addr[1:0]) != 2'h3}}) else $error("port 2 tie-off wrong");
  p5_tieoff_a: assert property (rd && addr[4:2] == 3'h2
    |=> rdata[7] && rdata[1] == ($past(addr[1:0]) != 2'h3)) else $error("port 5 tie-off wrong");
  p6_tieoff_a: assert property (rd && addr[4:2] == 3'h3
    |=> rdata[3:2] == {2{$past(addr[1:0]) != 2'h3}}) else $error("port 6 tie-off wrong");
  p0_low_a: assert property (rd && addr == 5'h10 |=> rdata[1:0] == 2'h0)
    else $error("port 0 tied bits not low");
  bus_idle_a: assert property (!rd |=> rdata == 8'h00)
    else $error("read data outside answer cycle");
  bonded_rw_a: assert property (wr && addr == 5'h01 ##2 rd && addr == 5'h01
    |=> rdata[3:0] == $past(wdata[3:0], 3)) else $error("bonded latch bits lost");
  fixed_pins_a: assert property (port1OutEn_n[7:4] == 4'hF && port6OutEn_n[3:2] == 2'h3)
    else $error("unbonded pin driven");
  adc_run_a: assert property (wr && addr == 5'h14 && !adcBusy
    |=> adcBusy ##[1:15] !adcBusy) else $error("conversion did not run and end");
endmodule

// ---- verif/ubpt_top_tb_top.sv ----
// Self-checking bench for the unbonded port tie-off block
`timescale 1ns/1ps
module ubpt_top_tb_top;
  logic mclk = 0, srst = 1, wr = 0, rd = 0, clockOutSrc = 0;
  logic [4:0] addr = '0;
  logic [7:0] wdata = '0, rdata, v, d;
  logic [7:0] po [4];
  logic [7:0] pe [4];
  logic [7:0] pins [5] = '{default: 8'h00};
  logic [9:0] adcSample = '0;
  logic adcBusy;
  int mismatches = 0, n_checks = 0, k;
  // Tie-off masks and fixed function values per slot
  logic [7:0] fix [4] = '{8'hF0, 8'h28, 8'h82, 8'h0C};
  logic [7:0] ffun [4] = '{8'h00, 8'h00, 8'h80, 8'h00};
  logic [7:0] mreg [16];
  ubpt_top u_dut (.mclk(mclk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .port0Pin(pins[4]), .port1Pin(pins[0]), .port2Pin(pins[1]),
    .port5Pin(pins[2]), .port6Pin(pins[3]), .port1Out(po[0]), .port1OutEn_n(pe[0]),
    .port2Out(po[1]), .port2OutEn_n(pe[1]), .port5Out(po[2]), .port5OutEn_n(pe[2]),
    .port6Out(po[3]), .port6OutEn_n(pe[3]),
    .clockOutSrc(clockOutSrc), .adcSample(adcSample), .adcBusy(adcBusy));
  initial forever #12.5 mclk = ~mclk;
  function automatic logic [7:0] expv(int i);
    logic [7:0] f;
    f = fix[i / 4];
    if (i % 4 == 0) return (pins[i / 4] & ~f) | f;
    if (i % 4 == 3) return (mreg[i] & ~f) | ffun[i / 4];
    return (mreg[i] & ~f) | f;
  endfunction
  // Pin drive model: fixed bits idle high, dir 1 pulls low only, clock output push-pull
  function automatic logic [7:0] expo(int s, bit en);
    logic [7:0] f, l, dr, o, e;
    f = fix[s];
    l = mreg[s * 4 + 1];
    dr = mreg[s * 4 + 2];
    o = (l & ~dr) | f;
    e = (l & dr) | f;
    if (s == 1 && mreg[7][7]) begin
      o[7] = clockOutSrc;
      e[7] = 1'b0;
    end
    return en ? e : o;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [4:0] a, input logic [7:0] dd);
    @(posedge mclk);
    addr <= a;
    wdata <= dd;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [4:0] a, output logic [7:0] q);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 q = rdata;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #100us;
    mismatches++;
    test_done();
  end
  initial begin
    k = $urandom(73);
    for (int i = 0; i < 16; i++) mreg[i] = (i % 4 == 3) ? 8'h00 : 8'hFF;
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      rreg(5'(i), v);
      chk(v, expv(i));
    end
    $display("reset view done");
    // Random pins and writes; fixed bits must not move
    @(posedge mclk);
    foreach (pins[j]) pins[j] <= 8'($urandom);
    for (int i = 0; i < 16; i++) begin
      d = 8'($urandom);
      if (i % 4 != 0) wreg(5'(i), d);
      if (i % 4 != 0) mreg[i] = d;
      rreg(5'(i), v);
      chk(v, expv(i));
    end
    rreg(5'h10, v);
    chk(v, pins[4] & 8'hFC);
    d = 8'($urandom);
    wreg(5'h11, d);
    rreg(5'h11, v);
    chk(v, d);
    rreg(5'h1C, v);
    chk(v, 8'h00);
    for (int s = 0; s < 4; s++) begin
      chk(po[s], expo(s, 1'b0));
      chk(pe[s], expo(s, 1'b1));
    end
    $display("write view done");
    // Tied channels give full scale, others the sample
    for (int c = 0; c < 3; c++) begin
      @(posedge mclk);
      adcSample <= 10'($urandom);
      wreg(5'h14, 8'(c));
      #1 k = 0;
      chk({7'h00, adcBusy}, 8'h01);
      while (adcBusy !== 1'b0 && k < 40) begin
        @(posedge mclk);
        #1 k++;
      end
      if (k >= 40) begin
        mismatches++;
        $display("CHECK FAILED %0t: conversion never ended", $time);
      end
      rreg(5'h14, v);
      chk(v, 8'h02);
      rreg(5'h17, v);
      chk(v, 8'(c));
      rreg(5'h15, v);
      chk(v, c < 2 ? 8'hFF : adcSample[7:0]);
      rreg(5'h16, v);
      chk(v, c < 2 ? 8'h03 : {6'h00, adcSample[9:8]});
    end
    $display("converter done");
    // Clock output stays push-pull even with open-drain direction
    wreg(5'h07, 8'h80);
    wreg(5'h06, 8'hFF);
    for (int c = 0; c < 2; c++) begin
      @(posedge mclk);
      clockOutSrc <= c[0];
      #1 chk({6'h00, pe[1][7], po[1][7]}, {7'h00, c[0]});
    end
    $display("clock output done");
    test_done();
  end
endmodule
bind ubpt_top ubpt_monitor u_mon (.mclk(mclk), .srst(srst), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .port1OutEn_n(port1OutEn_n),
  .port6OutEn_n(port6OutEn_n), .adcBusy(adcBusy));
